// ==== pmrp_pkg.sv ====
// shared constants, register layout and types of the mac-side data port
package pmrp_pkg;
	// register map
	localparam logic [15:0] CTRL_ADDR       = 16'h0017;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam int          THR_LSB         = 0;
	localparam int          MODE_LSB        = 4;
	localparam int          STAT_FULL_BIT   = 14;
	localparam int          STAT_STRAP_BIT  = 15;
	localparam logic [3:0]  THR_BASE        = 4'h2;
	localparam logic [1:0]  STRAP_SYNC_CNT  = 2'h2;

	// receive codes
	localparam logic [3:0]  RX_CODE_IDLE    = 4'h0;
	localparam logic [3:0]  RX_CODE_FC      = 4'he;

	// clock timing
	localparam int          CLK_NS          = 5;
	localparam int          MII_CLK_NS      = 40;
	localparam int          RMII_CLK_NS     = 20;
	localparam logic [2:0]  MII_HALF        = 3'(MII_CLK_NS / (2 * CLK_NS) - 1);
	localparam logic [2:0]  RMII_HALF       = 3'(RMII_CLK_NS / (2 * CLK_NS) - 1);

	// elastic buffer shape: entry is {flag, er, nibble}
	localparam int          FIFO_AW         = 3;
	localparam int          ENTRY_W         = 6;

	typedef enum logic [1:0] {
		MODE_MII         = 2'b00,
		MODE_RMII_SLAVE  = 2'b01,
		MODE_RMII_MASTER = 2'b10
	} pmrp_mode_e;

	typedef enum logic {
		RX_WAIT = 1'b0,
		RX_RUN  = 1'b1
	} pmrp_rxst_e;
endpackage

// ==== pmrp_if.sv ====
// link wires between the phy end and the mac end
`timescale 1ns/1ps
interface pmrp_if;
	// transmit pins, mac to phy
	logic       tx_en;
	logic       tx_er;
	logic [3:0] tx_d;
	// receive pins, phy to mac
	logic       rx_dv;
	logic       rx_er;
	logic       crs_dv;
	logic [3:0] rx_d;
	// clocks
	logic       phy_clk_o;
	logic       phy_clk_oe;
	logic       ref_clock_input_pin;
	logic       ref_clock_oe;
	wire        link_clk;
	wire        master_ref_clock_output_pin;

	// phy clock wins when it drives, otherwise the mac reference
	assign link_clk = phy_clk_oe ? phy_clk_o : ref_clock_input_pin;
	assign master_ref_clock_output_pin = phy_clk_oe & phy_clk_o;

	modport phy (
		input  tx_en, tx_er, tx_d, link_clk, ref_clock_input_pin,
		output rx_dv, rx_er, crs_dv, rx_d, phy_clk_o, phy_clk_oe
	);
	modport mac (
		input  rx_dv, rx_er, crs_dv, rx_d, link_clk, phy_clk_o,
		output tx_en, tx_er, tx_d, ref_clock_input_pin, ref_clock_oe
	);
endinterface

// ==== pmrp_phy_end.sv ====
// phy end of the mac data port with its clock-crossing elastic buffer
// Operation
// RQ1 - mii moves one 4-bit nibble per clock
// RQ2 - tx_en low idle, tx_er marks error
// RQ3 - mii receive idle, false carrier, error coding
// RQ4 - rmii slave runs from mac 50 mhz reference
// RQ5 - rmii master drives 50 mhz clock out
// RQ6 - rmii moves one dibit per 50 mhz clock
// RQ7 - mac holds tx_en low between frames
// RQ8 - rmii receive idle and error coding
// RQ9 - rmii samples and launches on rising edge
// RQ10 - separate rx_dv and rx_er in rmii
// RQ11 - elastic buffer with programmable start threshold
// RQ12 - software picks threshold from packet size
// RQ13 - mii clocks sourced by the phy
// RQ14 - mode taken from straps at reset
`timescale 1ns/1ps

module pmrp_afifo
	import pmrp_pkg::*;
#(
	parameter int W  = ENTRY_W,
	parameter int AW = FIFO_AW
) (
	// write side
	input  wire logic          wclk,
	input  wire logic          wrst,
	input  wire logic          wce,
	input  wire logic          wr_en,
	input  wire logic [W-1:0]  wr_data,
	output logic               wr_rdy,
	// read side
	input  wire logic          rclk,
	input  wire logic          rrst,
	input  wire logic          rce,
	input  wire logic          rd_en,
	output logic [W-1:0]       rd_data,
	output logic               rd_vld,
	output logic [AW:0]        rd_fill
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] mem;
		logic [AW:0]               bin;
		logic [AW:0]               gray;
		logic [AW:0]               q1;
		logic [AW:0]               q2;
		logic                      rdy;
	} pmrp_fw_s;
	typedef struct packed {
		logic [AW:0] bin;
		logic [AW:0] gray;
		logic [AW:0] q1;
		logic [AW:0] q2;
		logic        vld;
	} pmrp_fr_s;

	pmrp_fw_s w_q, w_d;
	pmrp_fr_s r_q, r_d;

	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// write side: the reader's gray pointer crosses in through two flops
	always_comb begin
		w_d = w_q;
		if (wce) begin
			w_d.q1 = r_q.gray;
			w_d.q2 = w_q.q1;
			if (wr_en && w_q.rdy) begin
				w_d.mem[w_q.bin[AW-1:0]] = wr_data;
				w_d.bin = w_q.bin + 1'b1;
			end
			w_d.gray = w_d.bin ^ (w_d.bin >> 1);
			w_d.rdy  = w_d.gray != {~w_q.q2[AW:AW-1], w_q.q2[AW-2:0]};
		end
	end

	always_ff @(posedge wclk or posedge wrst) begin
		if (wrst) begin
			w_q <= '{mem: '0, bin: '0, gray: '0, q1: '0, q2: '0, rdy: 1'b1};
		end else begin
			w_q <= w_d;
		end
	end

	// read side: empty is pessimistic by the two synchronizer flops and the vld register, never optimistic
	always_comb begin
		r_d = r_q;
		if (rce) begin
			r_d.q1 = w_q.gray;
			r_d.q2 = r_q.q1;
			if (rd_en && r_q.vld) begin
				r_d.bin = r_q.bin + 1'b1;
			end
			r_d.gray = r_d.bin ^ (r_d.bin >> 1);
			r_d.vld  = r_d.gray != r_q.q2;
		end
	end

	always_ff @(posedge rclk or posedge rrst) begin
		if (rrst) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign wr_rdy  = w_q.rdy;
	assign rd_vld  = r_q.vld;
	assign rd_data = w_q.mem[r_q.bin[AW-1:0]];
	assign rd_fill = g2b(r_q.q2) - r_q.bin;
endmodule // pmrp_afifo

module pmrp_phy_end
	import pmrp_pkg::*;
(
	// core clock
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// mode straps
	input  wire logic [1:0]  strap_mode,
	// register port
	input  wire logic        cfg_we,
	input  wire logic [15:0] cfg_addr,
	input  wire logic [15:0] cfg_wdata,
	output logic [15:0]      cfg_rdata,
	// receive stream from line logic
	input  wire logic        rx_in_valid,
	output logic             rx_in_ready,
	input  wire logic        rx_in_dv,
	input  wire logic        rx_in_er,
	input  wire logic        rx_in_fc,
	input  wire logic [3:0]  rx_in_d,
	// transmit stream to line logic
	output logic             tx_out_valid,
	output logic             tx_out_en,
	output logic             tx_out_er,
	output logic [3:0]       tx_out_d,
	// link
	pmrp_if.phy              lnk
);
	typedef struct packed {
		logic [1:0]  strap_s1;
		logic [1:0]  strap_s2;
		logic [1:0]  cap_cnt;
		logic        strap_done;
		logic [15:0] ctrl;
		logic [15:0] rdata;
		logic [2:0]  div_cnt;
		logic        clk_o;
		logic        clk_oe;
		logic        tx_v;
		logic        tx_en;
		logic        tx_er;
		logic [3:0]  tx_d;
	} pmrp_pc_s;
	typedef struct packed {
		logic        ce_s1;
		logic        ce_s2;
		logic [1:0]  mode_s1;
		logic [1:0]  mode_s2;
		logic [1:0]  thr_s1;
		logic [1:0]  thr_s2;
		pmrp_rxst_e  st;
		logic        half;
		logic [5:0]  cur;
		logic        rx_dv;
		logic        rx_er;
		logic        crs_dv;
		logic [3:0]  rx_d;
		logic        tx_half;
		logic [1:0]  tx_lo;
		logic        tx_en_prev;
	} pmrp_pl_s;

	pmrp_pc_s c_q, c_d;
	pmrp_pl_s l_q, l_d;

	logic               rxf_rd;
	logic [ENTRY_W-1:0] rxf_data;
	logic               rxf_vld;
	logic [FIFO_AW:0]   rxf_fill;
	logic               txf_wr;
	logic [ENTRY_W-1:0] txf_wdata;
	logic               txf_rdy;
	logic [ENTRY_W-1:0] txf_data;
	logic               txf_vld;
	logic [ENTRY_W-1:0] rx_entry;

	// false carrier is carried as a non-data entry with its code
	assign rx_entry = rx_in_fc ? {1'b0, 1'b1, RX_CODE_FC} : {rx_in_dv, rx_in_er, rx_in_d}; // RQ3

	pmrp_afifo u_rxf (
		.wclk    (clk),
		.wrst    (rst),
		.wce     (ce),
		.wr_en   (rx_in_valid),
		.wr_data (rx_entry),
		.wr_rdy  (rx_in_ready),
		.rclk    (lnk.link_clk),
		.rrst    (rst),
		.rce     (l_q.ce_s2),
		.rd_en   (rxf_rd),
		.rd_data (rxf_data),
		.rd_vld  (rxf_vld),
		.rd_fill (rxf_fill)
	);

	pmrp_afifo u_txf (
		.wclk    (lnk.link_clk),
		.wrst    (rst),
		.wce     (l_q.ce_s2),
		.wr_en   (txf_wr),
		.wr_data (txf_wdata),
		.wr_rdy  (txf_rdy),
		.rclk    (clk),
		.rrst    (rst),
		.rce     (ce),
		.rd_en   (1'b1),
		.rd_data (txf_data),
		.rd_vld  (txf_vld),
		.rd_fill ()
	);

	// core domain: straps, register, clock divider, transmit hand-off
	always_comb begin
		logic [2:0] half_cnt;
		half_cnt = (c_q.ctrl[MODE_LSB +: 2] == MODE_MII) ? MII_HALF : RMII_HALF;
		c_d = c_q;
		if (ce) begin
			c_d.strap_s1 = strap_mode;
			c_d.strap_s2 = c_q.strap_s1;
			if (!c_q.strap_done) begin
				c_d.cap_cnt = c_q.cap_cnt + 1'b1;
				if (c_q.cap_cnt == STRAP_SYNC_CNT) begin
					c_d.ctrl[MODE_LSB +: 2] = c_q.strap_s2; // RQ14
					c_d.strap_done = 1'b1;
				end
			end else if (cfg_we && cfg_addr == CTRL_ADDR) begin
				c_d.ctrl = cfg_wdata; // RQ11
			end
			if (cfg_addr == CTRL_ADDR) begin
				c_d.rdata = c_q.ctrl;
				c_d.rdata[STAT_FULL_BIT]  = ~rx_in_ready;
				c_d.rdata[STAT_STRAP_BIT] = c_q.strap_done;
			end else begin
				c_d.rdata = 16'h0000;
			end
			// rmii slave takes its clock from the mac, all else drive it
			c_d.clk_oe = c_q.strap_done && c_q.ctrl[MODE_LSB +: 2] != MODE_RMII_SLAVE; // RQ4 RQ13
			if (!c_q.clk_oe) begin
				c_d.div_cnt = 3'h0;
				c_d.clk_o   = 1'b0;
			end else if (c_q.div_cnt >= half_cnt) begin
				c_d.div_cnt = 3'h0;
				c_d.clk_o   = ~c_q.clk_o; // RQ5 RQ13
			end else begin
				c_d.div_cnt = c_q.div_cnt + 1'b1;
			end
			c_d.tx_v  = txf_vld;
			c_d.tx_en = txf_vld & txf_data[5];
			c_d.tx_er = txf_vld & txf_data[4];
			c_d.tx_d  = txf_vld ? txf_data[3:0] : 4'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			c_q      <= '0;
			c_q.ctrl <= CTRL_RESET;
		end else begin
			c_q <= c_d;
		end
	end

	// link domain: elastic read-out and transmit sampling
	always_comb begin
		logic       rmii;
		logic       slot;
		logic [5:0] e;
		logic [1:0] dib;
		rmii      = l_q.mode_s2 != MODE_MII;
		slot      = !rmii || !l_q.half;
		e         = l_q.cur;
		dib       = 2'b00;
		rxf_rd    = 1'b0;
		txf_wr    = 1'b0;
		txf_wdata = '0;
		l_d       = l_q;
		l_d.ce_s1 = ce;
		l_d.ce_s2 = l_q.ce_s1;
		if (l_q.ce_s2) begin
			l_d.mode_s1 = c_q.ctrl[MODE_LSB +: 2];
			l_d.mode_s2 = l_q.mode_s1;
			l_d.thr_s1  = c_q.ctrl[THR_LSB +: 2];
			l_d.thr_s2  = l_q.thr_s1;
			if (slot) begin
				e = 6'h00;
				if (l_q.st == RX_RUN && rxf_vld) begin
					e = rxf_data;
					rxf_rd = 1'b1;
				end else if (rxf_fill >= THR_BASE + {2'b00, l_q.thr_s2}) begin
					e = rxf_data; // RQ11
					rxf_rd = 1'b1;
					l_d.st = RX_RUN;
				end else begin
					l_d.st = RX_WAIT;
				end
				l_d.cur = e;
			end
			if (rmii) begin
				dib        = l_q.half ? e[3:2] : e[1:0]; // RQ6 RQ9
				l_d.half   = ~l_q.half;
				l_d.rx_dv  = e[5]; // RQ10
				l_d.crs_dv = e[5]; // RQ8
				l_d.rx_er  = e[5] & e[4];
				l_d.rx_d   = {2'b00, e[5] ? dib : 2'b00};
			end else begin
				l_d.half   = 1'b0;
				l_d.rx_dv  = e[5]; // RQ1 RQ3
				l_d.crs_dv = 1'b0;
				l_d.rx_er  = e[4];
				l_d.rx_d   = (e[5] || e[4]) ? e[3:0] : RX_CODE_IDLE;
			end
			// transmit: only tx_en opens a frame, tx_er alone is ignored
			l_d.tx_en_prev = lnk.tx_en;
			if (lnk.tx_en) begin
				if (!rmii) begin
					txf_wr    = 1'b1; // RQ2
					txf_wdata = {1'b1, lnk.tx_er, lnk.tx_d};
				end else if (!l_q.tx_half) begin
					l_d.tx_lo   = lnk.tx_d[1:0]; // RQ7 RQ9
					l_d.tx_half = 1'b1;
				end else begin
					txf_wr      = 1'b1;
					txf_wdata   = {1'b1, 1'b0, lnk.tx_d[1:0], l_q.tx_lo};
					l_d.tx_half = 1'b0;
				end
			end else begin
				l_d.tx_half = 1'b0;
				txf_wr      = l_q.tx_en_prev;
			end
			txf_wr = txf_wr & txf_rdy;
		end
	end

	always_ff @(posedge lnk.link_clk or posedge rst) begin
		if (rst) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// outputs
	assign cfg_rdata      = c_q.rdata;
	assign tx_out_valid   = c_q.tx_v;
	assign tx_out_en      = c_q.tx_en;
	assign tx_out_er      = c_q.tx_er;
	assign tx_out_d       = c_q.tx_d;
	assign lnk.phy_clk_o  = c_q.clk_o;
	assign lnk.phy_clk_oe = c_q.clk_oe;
	assign lnk.rx_dv      = l_q.rx_dv;
	assign lnk.rx_er      = l_q.rx_er;
	assign lnk.crs_dv     = l_q.crs_dv;
	assign lnk.rx_d       = l_q.rx_d;
endmodule // pmrp_phy_end

// ==== pmrp_mac_end.sv ====
// mac end of the data port: frames in and out over the link
`timescale 1ns/1ps
module pmrp_mac_end
	import pmrp_pkg::*;
(
	// core clock
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// link mode, static
	input  wire logic [1:0]  mode,
	// transmit stream from user
	input  wire logic        tx_in_valid,
	output logic             tx_in_ready,
	input  wire logic        tx_in_er,
	input  wire logic        tx_in_last,
	input  wire logic [3:0]  tx_in_d,
	// receive stream to user
	output logic             rx_out_valid,
	output logic             rx_out_end,
	output logic             rx_out_er,
	output logic [3:0]       rx_out_d,
	// link
	pmrp_if.mac              lnk
);
	typedef struct packed {
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic [2:0] div_cnt;
		logic       ref_o;
		logic       ref_oe;
		logic       rx_v;
		logic       rx_end;
		logic       rx_er;
		logic [3:0] rx_d;
	} pmrp_mc_s;
	typedef struct packed {
		logic       ce_s1;
		logic       ce_s2;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic       gap;
		logic       half;
		logic [5:0] cur;
		logic       tx_en;
		logic       tx_er;
		logic [3:0] tx_d;
		logic       rx_half;
		logic [1:0] rx_lo;
		logic       rx_er_lo;
		logic       rx_dv_prev;
		logic       fc_prev;
	} pmrp_ml_s;

	pmrp_mc_s c_q, c_d;
	pmrp_ml_s l_q, l_d;

	logic               txf_rd;
	logic [ENTRY_W-1:0] txf_data;
	logic               txf_vld;
	logic               rxf_wr;
	logic [ENTRY_W-1:0] rxf_wdata;
	logic               rxf_rdy;
	logic [ENTRY_W-1:0] rxf_data;
	logic               rxf_vld;

	pmrp_afifo u_txf (
		.wclk    (clk),
		.wrst    (rst),
		.wce     (ce),
		.wr_en   (tx_in_valid),
		.wr_data ({tx_in_last, tx_in_er, tx_in_d}),
		.wr_rdy  (tx_in_ready),
		.rclk    (lnk.link_clk),
		.rrst    (rst),
		.rce     (l_q.ce_s2),
		.rd_en   (txf_rd),
		.rd_data (txf_data),
		.rd_vld  (txf_vld),
		.rd_fill ()
	);

	pmrp_afifo u_rxf (
		.wclk    (lnk.link_clk),
		.wrst    (rst),
		.wce     (l_q.ce_s2),
		.wr_en   (rxf_wr),
		.wr_data (rxf_wdata),
		.wr_rdy  (rxf_rdy),
		.rclk    (clk),
		.rrst    (rst),
		.rce     (ce),
		.rd_en   (1'b1),
		.rd_data (rxf_data),
		.rd_vld  (rxf_vld),
		.rd_fill ()
	);

	// core domain: slave-mode reference divider and receive hand-off
	always_comb begin
		c_d = c_q;
		if (ce) begin
			// strap pin is asynchronous, so it passes two flops first
			c_d.mode_s1 = mode;
			c_d.mode_s2 = c_q.mode_s1;
			c_d.ref_oe  = c_q.mode_s2 == MODE_RMII_SLAVE; // RQ4
			if (!c_q.ref_oe) begin
				c_d.div_cnt = 3'h0;
				c_d.ref_o   = 1'b0;
			end else if (c_q.div_cnt >= RMII_HALF) begin
				c_d.div_cnt = 3'h0;
				c_d.ref_o   = ~c_q.ref_o;
			end else begin
				c_d.div_cnt = c_q.div_cnt + 1'b1;
			end
			c_d.rx_v   = rxf_vld;
			c_d.rx_end = rxf_vld & rxf_data[5];
			c_d.rx_er  = rxf_vld & rxf_data[4];
			c_d.rx_d   = rxf_vld ? rxf_data[3:0] : 4'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// link domain: launch nibbles or dibits, gather received ones
	always_comb begin
		logic rmii;
		logic fc;
		rmii      = l_q.mode_s2 != MODE_MII;
		fc        = !lnk.rx_dv && lnk.rx_er && lnk.rx_d == RX_CODE_FC;
		txf_rd    = 1'b0;
		rxf_wr    = 1'b0;
		rxf_wdata = '0;
		l_d       = l_q;
		l_d.ce_s1 = ce;
		l_d.ce_s2 = l_q.ce_s1;
		if (l_q.ce_s2) begin
			l_d.mode_s1 = mode;
			l_d.mode_s2 = l_q.mode_s1;
			if (rmii && l_q.half) begin
				l_d.tx_d = {2'b00, l_q.cur[3:2]}; // RQ6
				l_d.half = 1'b0;
			end else if (txf_vld && !l_q.gap) begin
				txf_rd    = 1'b1;
				l_d.cur   = txf_data;
				l_d.gap   = txf_data[5];
				l_d.tx_en = 1'b1; // RQ2 RQ7
				l_d.tx_er = !rmii && txf_data[4];
				l_d.tx_d  = rmii ? {2'b00, txf_data[1:0]} : txf_data[3:0]; // RQ1
				l_d.half  = rmii;
			end else begin
				l_d.gap   = 1'b0;
				l_d.tx_en = 1'b0;
				l_d.tx_er = 1'b0;
				l_d.tx_d  = 4'h0;
			end
			// receive side qualifies with rx_dv in both modes
			l_d.rx_dv_prev = lnk.rx_dv;
			l_d.fc_prev    = fc;
			if (lnk.rx_dv) begin
				if (!rmii) begin
					rxf_wr    = 1'b1;
					rxf_wdata = {1'b0, lnk.rx_er, lnk.rx_d};
				end else if (!l_q.rx_half) begin
					l_d.rx_lo    = lnk.rx_d[1:0];
					l_d.rx_er_lo = lnk.rx_er;
					l_d.rx_half  = 1'b1;
				end else begin
					rxf_wr      = 1'b1;
					rxf_wdata   = {1'b0, l_q.rx_er_lo | lnk.rx_er, lnk.rx_d[1:0], l_q.rx_lo};
					l_d.rx_half = 1'b0;
				end
			end else begin
				l_d.rx_half = 1'b0;
				if (l_q.rx_dv_prev) begin
					rxf_wr    = 1'b1;
					rxf_wdata = 6'h20;
				end else if (!rmii && fc && !l_q.fc_prev) begin
					rxf_wr    = 1'b1;
					rxf_wdata = {2'b11, RX_CODE_FC};
				end
			end
			rxf_wr = rxf_wr & rxf_rdy;
		end
	end

	always_ff @(posedge lnk.link_clk or posedge rst) begin
		if (rst) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// outputs
	assign rx_out_valid            = c_q.rx_v;
	assign rx_out_end              = c_q.rx_end;
	assign rx_out_er               = c_q.rx_er;
	assign rx_out_d                = c_q.rx_d;
	assign lnk.ref_clock_input_pin = c_q.ref_o;
	assign lnk.ref_clock_oe        = c_q.ref_oe;
	assign lnk.tx_en               = l_q.tx_en;
	assign lnk.tx_er               = l_q.tx_er;
	assign lnk.tx_d                = l_q.tx_d;
endmodule // pmrp_mac_end

// ==== pmrp_properties.sv ====
// link-side assertions for the mac data port, both ends in view
`timescale 1ns/1ps
module pmrp_properties (
	// clocks and reset
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       link_clk,
	// link pins
	input wire logic       tx_en,
	input wire logic       tx_er,
	input wire logic       rx_dv,
	input wire logic       rx_er,
	input wire logic       crs_dv,
	input wire logic [3:0] rx_d,
	input wire logic       phy_clk_o,
	input wire logic       phy_clk_oe,
	input wire logic       ref_clock_input_pin,
	input wire logic       ref_clock_oe
);
	// a nibble needs two dibit slots, so a frame never lasts one slot
	sequence s_two_dibits;
		rx_dv ##1 rx_dv;
	endsequence
	// phy clock half periods counted in core cycles
	sequence s_half_mii;
		phy_clk_o [*4] ##1 !phy_clk_o;
	endsequence
	sequence s_half_rmii;
		phy_clk_o [*2] ##1 !phy_clk_o;
	endsequence
	// mac reference half period in core cycles
	sequence s_half_ref;
		ref_clock_input_pin [*2] ##1 !ref_clock_input_pin;
	endsequence

	// receive and transmit coding
	property p_rx_code;
		@(posedge link_clk) disable iff (rst)
		(!rx_dv && rx_er) |-> (rx_d == 4'h0 || rx_d == 4'he);
	endproperty
	a_rx_code: assert property (p_rx_code) else $error("reserved receive code");
	property p_rx_rmii_code;
		@(posedge link_clk) disable iff (rst)
		(ref_clock_oe && !crs_dv && rx_er) |-> rx_d == 4'h0;
	endproperty
	a_rx_rmii_code: assert property (p_rx_rmii_code) else $error("rmii reserved code");
	property p_rmii_width;
		@(posedge link_clk) disable iff (rst) ref_clock_oe |-> rx_d[3:2] == 2'h0;
	endproperty
	a_rmii_width: assert property (p_rmii_width) else $error("rmii upper bits set");
	property p_rmii_pair;
		@(posedge link_clk) disable iff (rst) (ref_clock_oe && $rose(rx_dv)) |-> s_two_dibits;
	endproperty
	a_rmii_pair: assert property (p_rmii_pair) else $error("odd dibit frame");
	property p_rmii_crs;
		@(posedge link_clk) disable iff (rst) (ref_clock_oe && rx_dv) |-> crs_dv;
	endproperty
	a_rmii_crs: assert property (p_rmii_crs) else $error("valid without carrier");
	property p_tx_code;
		@(posedge link_clk) disable iff (rst) !tx_en |-> !tx_er;
	endproperty
	a_tx_code: assert property (p_tx_code) else $error("reserved transmit code");

	// clock sourcing
	property p_slave_clk;
		@(posedge clk) disable iff (rst) ref_clock_oe |-> !phy_clk_oe;
	endproperty
	a_slave_clk: assert property (p_slave_clk) else $error("two clock drivers");
	property p_ref_rate;
		@(posedge clk) disable iff (rst) (ref_clock_oe && $rose(ref_clock_input_pin))
		|-> s_half_ref;
	endproperty
	a_ref_rate: assert property (p_ref_rate) else $error("reference not 50 mhz");
	property p_phy_rate;
		@(posedge clk) disable iff (rst) (phy_clk_oe && $rose(phy_clk_o))
		|-> s_half_mii or s_half_rmii;
	endproperty
	a_phy_rate: assert property (p_phy_rate) else $error("phy clock rate wrong");
	property p_oe_hold;
		@(posedge clk) disable iff (rst) $rose(phy_clk_oe) |=> phy_clk_oe [*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("clock drive dropped");
endmodule // pmrp_properties

// ==== testbench.sv ====
// two-ended bench: phy end and mac end joined over one link
`timescale 1ns/1ps
module testbench;
	import pmrp_pkg::*;
	typedef struct packed {
		pmrp_mode_e mode;
		logic [1:0] thr;
		logic [3:0] base;
	} pmrp_row_s;
	// mode, threshold code, first nibble
	localparam pmrp_row_s ROWS [4] = '{'{MODE_MII, 2'h0, 4'h1}, '{MODE_RMII_SLAVE, 2'h1, 4'h5},
		'{MODE_RMII_MASTER, 2'h2, 4'h9}, '{MODE_MII, 2'h3, 4'hc}};
	logic        clk, rst, ce, cfg_we, rx_in_valid, rx_in_ready, rx_in_dv, rx_in_er, rx_in_fc;
	logic        tx_out_valid, tx_out_en, tx_out_er, tx_in_valid, tx_in_ready, tx_in_er;
	logic        tx_in_last, rx_out_valid, rx_out_end, rx_out_er, bad_valid;
	logic [1:0]  strap;
	logic [3:0]  rx_in_d, tx_out_d, tx_in_d, rx_out_d;
	logic [15:0] cfg_addr, cfg_wdata, cfg_rdata;
	logic [5:0]  tx_q [$];
	logic [5:0]  rx_q [$];
	int          err_total, compares, cyc, bad_cnt;

	pmrp_if lnk_if ();
	pmrp_if bad_if ();
	// second link: mac side breaks the idle coding on purpose
	assign bad_if.tx_en = 1'h0;
	assign bad_if.tx_er = 1'h1;
	assign bad_if.tx_d = 4'hf;
	assign bad_if.ref_clock_input_pin = lnk_if.link_clk;
	assign bad_if.ref_clock_oe = 1'h0;

	pmrp_phy_end pmrp_phy_end_inst (.clk(clk), .rst(rst), .ce(ce), .strap_mode(strap),
		.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in_dv(rx_in_dv),
		.rx_in_er(rx_in_er), .rx_in_fc(rx_in_fc), .rx_in_d(rx_in_d), .tx_out_valid(tx_out_valid),
		.tx_out_en(tx_out_en), .tx_out_er(tx_out_er), .tx_out_d(tx_out_d), .lnk(lnk_if.phy));
	pmrp_mac_end pmrp_mac_end_inst (.clk(clk), .rst(rst), .ce(ce), .mode(strap),
		.tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_er(tx_in_er),
		.tx_in_last(tx_in_last), .tx_in_d(tx_in_d), .rx_out_valid(rx_out_valid),
		.rx_out_end(rx_out_end), .rx_out_er(rx_out_er), .rx_out_d(rx_out_d), .lnk(lnk_if.mac));
	pmrp_phy_end bad_phy_inst (.clk(clk), .rst(rst), .ce(ce), .strap_mode(strap),
		.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(),
		.rx_in_valid(rx_in_valid), .rx_in_ready(), .rx_in_dv(rx_in_dv), .rx_in_er(rx_in_er),
		.rx_in_fc(rx_in_fc), .rx_in_d(rx_in_d), .tx_out_valid(bad_valid), .tx_out_en(),
		.tx_out_er(), .tx_out_d(), .lnk(bad_if.phy));
	pmrp_properties props_inst (.clk(clk), .rst(rst), .link_clk(lnk_if.link_clk),
		.tx_en(lnk_if.tx_en), .tx_er(lnk_if.tx_er), .rx_dv(lnk_if.rx_dv), .rx_er(lnk_if.rx_er),
		.crs_dv(lnk_if.crs_dv), .rx_d(lnk_if.rx_d), .phy_clk_o(lnk_if.phy_clk_o),
		.phy_clk_oe(lnk_if.phy_clk_oe), .ref_clock_input_pin(lnk_if.ref_clock_input_pin),
		.ref_clock_oe(lnk_if.ref_clock_oe));

	// core clock, 5 ns
	always #2.5 clk = ~clk;

	// capture stream outputs; the cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tx_out_valid) tx_q.push_back({tx_out_en, tx_out_er, tx_out_d});
		if (rx_out_valid) rx_q.push_back({rx_out_end, rx_out_er, rx_out_d});
		if (bad_valid) bad_cnt <= bad_cnt + 1;
		if (cyc == 60000) begin
			err_total++;
			results();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// strap is set while reset is high so the phy captures it on the third clock after release
	task automatic do_reset(input logic [1:0] m);
		rst <= 1'h1;
		strap <= m;
		repeat (6) @(posedge clk);
		check(16'({rx_in_ready, tx_in_ready, lnk_if.phy_clk_oe, lnk_if.ref_clock_oe}), 16'hc);
		rst <= 1'h0;
		repeat (200) @(posedge clk);
		tx_q.delete();
		rx_q.delete();
	endtask
	task automatic cfg_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_we <= 1'h1;
		@(posedge clk);
		cfg_we <= 1'h0;
	endtask
	task automatic cfg_rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge clk);
		cfg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		v = cfg_rdata;
	endtask
	// ready is registered, so it is looked at mid-cycle before the taking edge
	task automatic send_tx(input int n, input logic [3:0] b);
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			tx_in_valid <= 1'h1;
			tx_in_d <= b + 4'(i);
			tx_in_er <= (i == 3);
			tx_in_last <= (i == n - 1);
			@(negedge clk);
			while (tx_in_ready !== 1'h1) @(negedge clk);
			@(posedge clk);
		end
		tx_in_valid <= 1'h0;
	endtask
	task automatic push_rx(input logic dv, input logic er, input logic fc, input logic [3:0] d);
		@(posedge clk);
		rx_in_valid <= 1'h1;
		rx_in_dv <= dv;
		rx_in_er <= er;
		rx_in_fc <= fc;
		rx_in_d <= d;
		@(negedge clk);
		while (rx_in_ready !== 1'h1) @(negedge clk);
		@(posedge clk);
		rx_in_valid <= 1'h0;
	endtask
	task automatic wait_n(input int nt, input int nr);
		for (int k = 0; k < 3000 && (tx_q.size() < nt || rx_q.size() < nr); k++)
			@(posedge clk);
		repeat (50) @(posedge clk);
	endtask

	initial begin
		logic [15:0] v;
		pmrp_row_s   w;
		int          o;
		clk = 1'h0;
		{rst, ce, strap, cfg_we, cfg_addr, cfg_wdata} = {1'h1, 1'h1, 35'h0};
		{rx_in_valid, rx_in_dv, rx_in_er, rx_in_fc, rx_in_d} = 8'h0;
		{tx_in_valid, tx_in_er, tx_in_last, tx_in_d} = 7'h0;
		{err_total, compares, cyc, bad_cnt} = 128'h0;
		// one row per threshold code; mii mode is used in two of the rows
		foreach (ROWS[r]) begin
			w = ROWS[r];
			o = (w.mode == MODE_MII);
			do_reset(w.mode);
			cfg_rd(CTRL_ADDR, v);
			check(v, {1'h1, 9'h0, w.mode, 4'h0});
			cfg_wr(CTRL_ADDR, {10'h0, w.mode, 2'h0, w.thr});
			cfg_rd(CTRL_ADDR, v);
			check(v, {1'h1, 9'h0, w.mode, 2'h0, w.thr});
			cfg_rd(16'h0018, v);
			check(v, 16'h0);
			send_tx(8, w.base);
			push_rx(1'h0, 1'h0, 1'h1, 4'h0);
			for (int i = 0; i < 8; i++)
				push_rx(1'h1, i == 5, 1'h0, ~(w.base + 4'(i)));
			push_rx(1'h0, 1'h0, 1'h0, 4'h0);
			wait_n(9, 9 + o);
			check(16'(tx_q.size()), 16'h9);
			check(16'(rx_q.size()), 16'(9 + o));
			if (o == 1) check(16'(rx_q[0]), 16'h3e);
			for (int i = 0; i < 8; i++) begin
				check(16'(tx_q[i]), {10'h0, 1'h1, 1'(o == 1 && i == 3), w.base + 4'(i)});
				check(16'(rx_q[i + o]), {11'h0, 1'(i == 5), ~(w.base + 4'(i))});
			end
			check(16'(tx_q[8][5]), 16'h0);
			check(16'(rx_q[8 + o][5:4]), 16'h2);
		end
		// start threshold of five entries holds back a short frame
		rx_q.delete();
		for (int i = 0; i < 4; i++)
			push_rx(1'h1, 1'h0, 1'h0, 4'(i));
		repeat (300) @(posedge clk);
		check(16'(rx_q.size()), 16'h0);
		push_rx(1'h1, 1'h0, 1'h0, 4'h4);
		push_rx(1'h0, 1'h0, 1'h0, 4'h0);
		wait_n(0, 6);
		check(16'(rx_q.size()), 16'h6);
		check(16'(rx_q[4]), 16'h4);
		check(16'(bad_cnt), 16'h0);
		// core frozen by ce low: a write in that time is lost
		ce <= 1'h0;
		cfg_wr(CTRL_ADDR, 16'h0001);
		ce <= 1'h1;
		cfg_rd(CTRL_ADDR, v);
		check(v, 16'h8003);
		results();
	end
endmodule // testbench
